// ---- verilog/axi_apb_bridge.sv ----
// Purpose: AXI4-Lite slave to APB master bridge, one transfer at a time
// Assumes: apb slaves share the clock; with two or more, each owns a 2**SLOT_BITS byte slot; a lone slave takes every address
// Notes:   reset is sampled on the clock; pclk and presetn are forwarded
//
// Overview of operation
// - master holds read address until ready
// - all outputs low after reset
// - rvalid only with data and response present
// - master takes data with rready; bridge holds
// - apb clock is the axi clock
// - apb reset is the axi reset
// - 32-bit address on paddr
// - pprot and pstrb driven only in apb4
// - one select per slave, parameter count
// - penable low first cycle, then high
// - pwrite high write, low read
// - pwdata carries write data
// - hold transfer until selected pready
// - slave drives read data, bridge captures
// - sample pslverr at transfer completion
// - never return exclusive okay
// - apb address equals axi address
// - read wins over simultaneous write
// - reset synchronous, resets both sides
`include "apb_bridge_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module axi_apb_bridge #(
    parameter int NUM_SLAVES             = 1,
    parameter int SLOT_BITS              = `BR_SLOT_BITS,
    parameter bit periph_protocol_choice = 1'b0  // 1: apb4, 0: apb3
) (
    // clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_arst_n,
    // axi4-lite slave link
    axi_lite_link.bridge                      axi,
    // apb forwarded clock and reset
    output wire logic                         o_pclk,
    output wire logic                         o_presetn,
    // apb master request
    output logic [NUM_SLAVES-1:0]             o_psel,
    output logic                              o_penable,
    output logic                              o_pwrite,
    output apb_bridge_pkg::addr_t             o_paddr,
    output apb_bridge_pkg::data_t             o_pwdata,
    output apb_bridge_pkg::strb_t             o_pstrb,
    output apb_bridge_pkg::prot_t             o_pprot,
    // apb slave answers
    input  wire logic [NUM_SLAVES-1:0]        i_pready,
    input  wire logic [NUM_SLAVES-1:0]        i_pslverr,
    input  wire apb_bridge_pkg::data_t        i_prdata
);
    import apb_bridge_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // forwarded clock and reset

    assign o_pclk    = i_clk;
    assign o_presetn = i_arst_n;

    ////////////////////////////////////////////////////////////////////////
    // slot decode

    // one-hot select of the slave whose slot holds the address
    function automatic logic [NUM_SLAVES-1:0] slot_onehot(input addr_t a);
        logic [NUM_SLAVES-1:0] hot;
        addr_t                 idx;
        hot = '0;
        idx = (NUM_SLAVES == 1) ? `BR_ZERO_ADDR : (a >> SLOT_BITS);
        for (int i = 0; i < NUM_SLAVES; i++) begin
            if (idx == addr_t'(i)) begin
                hot[i] = 1'b1;
            end
        end
        return hot;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    bridge_state_e         state_reg,   state_next;   // sequencer
    logic [NUM_SLAVES-1:0] psel_reg,    psel_next;    // apb selects
    logic                  penable_reg, penable_next; // access phase
    logic                  pwrite_reg,  pwrite_next;  // direction
    addr_t                 paddr_reg,   paddr_next;   // apb address
    data_t                 pwdata_reg,  pwdata_next;  // write data
    strb_t                 pstrb_reg,   pstrb_next;   // byte strobes
    prot_t                 pprot_reg,   pprot_next;   // protection
    logic                  arready_reg, arready_next; // read addr taken
    logic                  wready_reg,  wready_next;  // write addr+data taken
    logic                  rvalid_reg,  rvalid_next;  // read answer valid
    data_t                 rdata_reg,   rdata_next;   // read answer data
    resp_t                 rresp_reg,   rresp_next;   // read answer code
    logic                  bvalid_reg,  bvalid_next;  // write answer valid
    resp_t                 bresp_reg,   bresp_next;   // write answer code

    logic [NUM_SLAVES-1:0] hit;       // decode of the pending request
    logic                  sel_ready; // pready of the selected slave
    logic                  sel_err;   // pslverr of the selected slave

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    // sequences one apb transfer per accepted axi request to a mapped slot
    always_comb begin
        state_next   = state_reg;
        psel_next    = psel_reg;
        penable_next = penable_reg;
        pwrite_next  = pwrite_reg;
        paddr_next   = paddr_reg;
        pwdata_next  = pwdata_reg;
        pstrb_next   = pstrb_reg;
        pprot_next   = pprot_reg;
        arready_next = 1'b0;
        wready_next  = 1'b0;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        hit          = '0;
        sel_ready    = |(i_pready & psel_reg);
        sel_err      = |(i_pslverr & psel_reg);
        case (state_reg)
            BR_IDLE: begin
                if (axi.arvalid) begin
                    hit          = slot_onehot(axi.araddr);
                    arready_next = 1'b1;
                    paddr_next   = axi.araddr;
                    pwrite_next  = 1'b0;
                    pstrb_next   = `BR_ZERO_STRB;
                    pprot_next   = periph_protocol_choice ?
                                   axi.arprot : `BR_ZERO_PROT;
                    if (|hit) begin
                        psel_next  = hit;
                        state_next = BR_SETUP;
                    end else begin
                        // unmapped slot: error answer, no apb cycle
                        rvalid_next = 1'b1;
                        rdata_next  = `BR_ZERO_DATA;
                        rresp_next  = `BR_RESP_SLVERR;
                        state_next  = BR_RDONE;
                    end
                end else if (axi.awvalid && axi.wvalid) begin
                    hit         = slot_onehot(axi.awaddr);
                    wready_next = 1'b1;
                    paddr_next  = axi.awaddr;
                    pwrite_next = 1'b1;
                    pwdata_next = axi.wdata;
                    pstrb_next  = periph_protocol_choice ?
                                  axi.wstrb : `BR_ZERO_STRB;
                    pprot_next  = periph_protocol_choice ?
                                  axi.awprot : `BR_ZERO_PROT;
                    if (|hit) begin
                        psel_next  = hit;
                        state_next = BR_SETUP;
                    end else begin
                        bvalid_next = 1'b1;
                        bresp_next  = `BR_RESP_SLVERR;
                        state_next  = BR_BDONE;
                    end
                end
            end
            BR_SETUP: begin
                // enable rises for the second cycle
                penable_next = 1'b1;
                state_next   = BR_ACCESS;
            end
            BR_ACCESS: begin
                // hold everything until the slave is ready
                if (sel_ready) begin
                    psel_next    = '0;
                    penable_next = 1'b0;
                    pstrb_next   = `BR_ZERO_STRB;
                    if (pwrite_reg) begin
                        bvalid_next = 1'b1;
                        bresp_next  = sel_err ? `BR_RESP_SLVERR
                                              : `BR_RESP_OKAY;
                        state_next  = BR_BDONE;
                    end else begin
                        rvalid_next = 1'b1;
                        rdata_next  = i_prdata;
                        rresp_next  = sel_err ? `BR_RESP_SLVERR
                                              : `BR_RESP_OKAY;
                        state_next  = BR_RDONE;
                    end
                end
            end
            BR_RDONE: begin
                if (axi.rready) begin
                    rvalid_next = 1'b0;
                    state_next  = BR_IDLE;
                end
            end
            BR_BDONE: begin
                // write answer held until bready
                if (axi.bready) begin
                    bvalid_next = 1'b0;
                    state_next  = BR_IDLE;
                end
            end
            default: begin
                state_next = BR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // reset sampled on the clock, all outputs low
    always_ff @(posedge i_clk) begin
        if (!i_arst_n) begin
            state_reg   <= BR_IDLE;
            psel_reg    <= '0;
            penable_reg <= 1'b0;
            pwrite_reg  <= 1'b0;
            paddr_reg   <= `BR_ZERO_ADDR;
            pwdata_reg  <= `BR_ZERO_DATA;
            pstrb_reg   <= `BR_ZERO_STRB;
            pprot_reg   <= `BR_ZERO_PROT;
            arready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= `BR_ZERO_DATA;
            rresp_reg   <= `BR_ZERO_RESP;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `BR_ZERO_RESP;
        end else begin
            state_reg   <= state_next;
            psel_reg    <= psel_next;
            penable_reg <= penable_next;
            pwrite_reg  <= pwrite_next;
            paddr_reg   <= paddr_next;
            pwdata_reg  <= pwdata_next;
            pstrb_reg   <= pstrb_next;
            pprot_reg   <= pprot_next;
            arready_reg <= arready_next;
            wready_reg  <= wready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // apb side
    assign o_psel      = psel_reg;
    assign o_penable   = penable_reg;
    assign o_pwrite    = pwrite_reg;
    assign o_paddr     = paddr_reg;
    assign o_pwdata    = pwdata_reg;
    assign o_pstrb     = pstrb_reg;
    assign o_pprot     = pprot_reg;
    // axi side
    assign axi.arready = arready_reg;
    assign axi.rvalid  = rvalid_reg;
    assign axi.rdata   = rdata_reg;
    assign axi.rresp   = rresp_reg;
    assign axi.awready = wready_reg;
    assign axi.wready  = wready_reg;
    assign axi.bvalid  = bvalid_reg;
    assign axi.bresp   = bresp_reg;

endmodule

`default_nettype wire

// ---- inc/apb_bridge_cfg.svh ----
// Purpose: shared constants for the AXI4-Lite to APB bridge and its master
// Assumes: 32-bit address and data on both sides
// Notes:   definitions only, no logic
`ifndef APB_BRIDGE_CFG_SVH
`define APB_BRIDGE_CFG_SVH

// bus widths
`define BR_ADDR_W      32
`define BR_DATA_W      32
`define BR_STRB_W      4
`define BR_PROT_W      3
`define BR_RESP_W      2

// axi response codes (exclusive okay is never produced)
`define BR_RESP_OKAY   2'h0
`define BR_RESP_SLVERR 2'h2

// default address slot size per apb slave, as a bit position
`define BR_SLOT_BITS   12

// reset values of every bridge and master output
`define BR_ZERO_ADDR   32'h0000_0000
`define BR_ZERO_DATA   32'h0000_0000
`define BR_ZERO_STRB   4'h0
`define BR_ZERO_PROT   3'h0
`define BR_ZERO_RESP   2'h0

`endif

// ---- inc/apb_bridge_pkg.sv ----
// Purpose: types shared by the bridge, its master end and the link
// Assumes: constants come from apb_bridge_cfg.svh
// Notes:   types only
`include "apb_bridge_cfg.svh"

package apb_bridge_pkg;

    // data and address words
    typedef logic [`BR_ADDR_W-1:0] addr_t;
    typedef logic [`BR_DATA_W-1:0] data_t;
    typedef logic [`BR_STRB_W-1:0] strb_t;
    typedef logic [`BR_PROT_W-1:0] prot_t;
    typedef logic [`BR_RESP_W-1:0] resp_t;

    // bridge sequencer states
    typedef enum logic [2:0] {
        BR_IDLE,
        BR_SETUP,
        BR_ACCESS,
        BR_RDONE,
        BR_BDONE
    } bridge_state_e;

    // master end channel phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_RESP
    } phase_e;

endpackage

// ---- inc/axi_lite_link.sv ----
// Purpose: AXI4-Lite link joining the master end and the bridge end
// Assumes: one clock for both ends, supplied by the modules
// Notes:   no clocking block; plain wires with one modport per party
`timescale 1ns/1ps
`default_nettype none

interface axi_lite_link;
    import apb_bridge_pkg::*;

    // read address channel
    logic  arvalid;
    logic  arready;
    addr_t araddr;
    prot_t arprot;
    // read data channel
    logic  rvalid;
    logic  rready;
    data_t rdata;
    resp_t rresp;
    // write address channel
    logic  awvalid;
    logic  awready;
    addr_t awaddr;
    prot_t awprot;
    // write data channel
    logic  wvalid;
    logic  wready;
    data_t wdata;
    strb_t wstrb;
    // write response channel
    logic  bvalid;
    logic  bready;
    resp_t bresp;

    // bridge side: axi slave
    modport bridge (
        input  arvalid, araddr, arprot, rready,
        input  awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
        output arready, rvalid, rdata, rresp,
        output awready, wready, bvalid, bresp
    );

    // master side
    modport master (
        output arvalid, araddr, arprot, rready,
        output awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
        input  arready, rvalid, rdata, rresp,
        input  awready, wready, bvalid, bresp
    );

endinterface

`default_nettype wire

// ---- verilog/axi_lite_requester.sv ----
// Purpose: AXI4-Lite master end that turns user requests into link traffic
// Assumes: same clock as the bridge; one read and one write outstanding
// Notes:   reset is sampled on the clock, like the bridge
`include "apb_bridge_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module axi_lite_requester (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    // axi4-lite master link
    axi_lite_link.master               axi,
    // user read request
    input  wire logic                  i_rd_req,
    input  wire apb_bridge_pkg::addr_t i_rd_addr,
    input  wire apb_bridge_pkg::prot_t i_rd_prot,
    // user read answer
    output logic                       o_rd_busy,
    output logic                       o_rd_done,
    output apb_bridge_pkg::data_t      o_rd_data,
    output apb_bridge_pkg::resp_t      o_rd_resp,
    // user write request
    input  wire logic                  i_wr_req,
    input  wire apb_bridge_pkg::addr_t i_wr_addr,
    input  wire apb_bridge_pkg::data_t i_wr_data,
    input  wire apb_bridge_pkg::strb_t i_wr_strb,
    input  wire apb_bridge_pkg::prot_t i_wr_prot,
    // user write answer
    output logic                       o_wr_busy,
    output logic                       o_wr_done,
    output apb_bridge_pkg::resp_t      o_wr_resp
);
    import apb_bridge_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    phase_e rph_reg,   rph_next;   // read channel phase
    addr_t  araddr_reg, araddr_next;
    prot_t  arprot_reg, arprot_next;
    logic   rdone_reg, rdone_next; // one-cycle read completion
    data_t  rdat_reg,  rdat_next;
    resp_t  rres_reg,  rres_next;
    phase_e wph_reg,   wph_next;   // write channel phase
    addr_t  awaddr_reg, awaddr_next;
    prot_t  awprot_reg, awprot_next;
    data_t  wdata_reg, wdata_next;
    strb_t  wstrb_reg, wstrb_next;
    logic   wdone_reg, wdone_next; // one-cycle write completion
    resp_t  bres_reg,  bres_next;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    // read and write channels advance independently
    always_comb begin
        rph_next    = rph_reg;
        araddr_next = araddr_reg;
        arprot_next = arprot_reg;
        rdone_next  = 1'b0;
        rdat_next   = rdat_reg;
        rres_next   = rres_reg;
        wph_next    = wph_reg;
        awaddr_next = awaddr_reg;
        awprot_next = awprot_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        wdone_next  = 1'b0;
        bres_next   = bres_reg;
        case (rph_reg)
            PH_IDLE: begin
                // capture the request; ignored while busy
                if (i_rd_req) begin
                    araddr_next = i_rd_addr;
                    arprot_next = i_rd_prot;
                    rph_next    = PH_ADDR;
                end
            end
            PH_ADDR: begin
                if (axi.arready) begin
                    rph_next = PH_RESP;
                end
            end
            PH_RESP: begin
                // rready high while waiting for data
                if (axi.rvalid) begin
                    rdat_next  = axi.rdata;
                    rres_next  = axi.rresp;
                    rdone_next = 1'b1;
                    rph_next   = PH_IDLE;
                end
            end
            default: begin
                rph_next = PH_IDLE;
            end
        endcase
        case (wph_reg)
            PH_IDLE: begin
                // capture the request; ignored while busy
                if (i_wr_req) begin
                    awaddr_next = i_wr_addr;
                    awprot_next = i_wr_prot;
                    wdata_next  = i_wr_data;
                    wstrb_next  = i_wr_strb;
                    wph_next    = PH_ADDR;
                end
            end
            PH_ADDR: begin
                // address and data offered together, taken together
                if (axi.awready) begin
                    wph_next = PH_RESP;
                end
            end
            PH_RESP: begin
                if (axi.bvalid) begin
                    bres_next  = axi.bresp;
                    wdone_next = 1'b1;
                    wph_next   = PH_IDLE;
                end
            end
            default: begin
                wph_next = PH_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // reset sampled on the clock, everything low
    always_ff @(posedge i_clk) begin
        if (!i_arst_n) begin
            rph_reg    <= PH_IDLE;
            araddr_reg <= `BR_ZERO_ADDR;
            arprot_reg <= `BR_ZERO_PROT;
            rdone_reg  <= 1'b0;
            rdat_reg   <= `BR_ZERO_DATA;
            rres_reg   <= `BR_ZERO_RESP;
            wph_reg    <= PH_IDLE;
            awaddr_reg <= `BR_ZERO_ADDR;
            awprot_reg <= `BR_ZERO_PROT;
            wdata_reg  <= `BR_ZERO_DATA;
            wstrb_reg  <= `BR_ZERO_STRB;
            wdone_reg  <= 1'b0;
            bres_reg   <= `BR_ZERO_RESP;
        end else begin
            rph_reg    <= rph_next;
            araddr_reg <= araddr_next;
            arprot_reg <= arprot_next;
            rdone_reg  <= rdone_next;
            rdat_reg   <= rdat_next;
            rres_reg   <= rres_next;
            wph_reg    <= wph_next;
            awaddr_reg <= awaddr_next;
            awprot_reg <= awprot_next;
            wdata_reg  <= wdata_next;
            wstrb_reg  <= wstrb_next;
            wdone_reg  <= wdone_next;
            bres_reg   <= bres_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // link side, decoded from phase flops
    assign axi.arvalid = (rph_reg == PH_ADDR);
    assign axi.araddr  = araddr_reg;
    assign axi.arprot  = arprot_reg;
    assign axi.rready  = (rph_reg == PH_RESP);
    assign axi.awvalid = (wph_reg == PH_ADDR);
    assign axi.wvalid  = (wph_reg == PH_ADDR);
    assign axi.awaddr  = awaddr_reg;
    assign axi.awprot  = awprot_reg;
    assign axi.wdata   = wdata_reg;
    assign axi.wstrb   = wstrb_reg;
    assign axi.bready  = (wph_reg == PH_RESP);
    // user side
    assign o_rd_busy   = (rph_reg != PH_IDLE);
    assign o_rd_done   = rdone_reg;
    assign o_rd_data   = rdat_reg;
    assign o_rd_resp   = rres_reg;
    assign o_wr_busy   = (wph_reg != PH_IDLE);
    assign o_wr_done   = wdone_reg;
    assign o_wr_resp   = bres_reg;

endmodule

`default_nettype wire

// ---- verification/axi_apb_bridge_sva.sv ----
// Purpose: assertions on the link and the apb side of the bridge
// Assumes: one clock; reset sampled on it
// Notes:   inputs mirror link and bridge signals
`timescale 1ns/1ps
`default_nettype none
module axi_apb_bridge_sva
    import apb_bridge_pkg::*;
#(parameter int NUM_SLAVES = 1) (
    input wire logic i_clk, i_arst_n, arvalid, arready, rvalid, rready,
    input wire logic o_penable, o_pwrite,
    input wire addr_t araddr, o_paddr,
    input wire data_t rdata, i_prdata,
    input wire resp_t rresp,
    input wire strb_t o_pstrb,
    input wire logic [NUM_SLAVES-1:0] o_psel, i_pready, i_pslverr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // transfer completes; error of the selected slave
    wire fin = o_penable && |(o_psel & i_pready);
    wire bad = |(o_psel & i_pslverr);
    AST_RESET: assert property (disable iff (1'b0) !i_arst_n |=>
        !arready && !rvalid && !o_penable && !(|o_psel)) else $error("reset");
    AST_HOLD: assert property (rvalid && !rready |=> rvalid &&
        $stable(rdata) && $stable(rresp)) else $error("rvalid hold");
    AST_SETUP: assert property ($rose(|o_psel) |-> !o_penable ##1
        o_penable) else $error("enable phase");
    AST_STALL: assert property (o_penable && !fin |=> o_penable &&
        $stable(o_psel) && $stable(o_paddr)) else $error("stall");
    AST_RDATA: assert property (fin && !o_pwrite |=> rvalid &&
        rdata == $past(i_prdata)) else $error("read data");
    AST_RRESP: assert property (fin && !o_pwrite |=>
        rresp == ($past(bad) ? 2'h2 : 2'h0)) else $error("read resp");
    AST_RSTRB: assert property (|o_psel && !o_pwrite |->
        o_pstrb == 4'h0) else $error("read strobe");
    AST_ADDR: assert property (arvalid && arready && |o_psel |->
        o_paddr == araddr && !o_pwrite) else $error("address");
    cover property (arvalid && arready);
    cover property (fin && o_pwrite);
    cover property (rvalid && rresp == 2'h2);
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: self-checking bench for requester, link and bridge
// Assumes: two apb slaves, apb4 on, slots of 2**12 bytes
// Notes:   the apb slave stalls, answers and fails at random
`timescale 1ns/1ps
`default_nettype none
module tb;
    import apb_bridge_pkg::*;
    logic i_clk = 0, i_arst_n = 0, i_rd_req = 0, i_wr_req = 0;
    logic o_rd_busy, o_rd_done, o_wr_busy, o_wr_done, o_penable, o_pwrite;
    logic o_pclk, o_presetn;
    logic [1:0] o_psel, i_pready = 0, i_pslverr = 0;
    addr_t i_rd_addr = 0, i_wr_addr = 0, o_paddr, e_a;
    data_t i_wr_data = 0, i_prdata = 0, o_rd_data, o_pwdata, e_d;
    strb_t i_wr_strb = 0, o_pstrb;
    prot_t i_rd_prot = 0, i_wr_prot = 0, o_pprot;
    resp_t o_rd_resp, o_wr_resp, e_r;
    logic [31:0] s0 = 32'hD, s1 = 32'hD;
    int mismatches = 0, tests_run = 0;
    axi_lite_link axi ();
    axi_lite_requester u_axi_lite_requester (.*);
    axi_apb_bridge #(.NUM_SLAVES(2), .periph_protocol_choice(1'b1))
        u_axi_apb_bridge (.*);
    axi_apb_bridge_sva #(.NUM_SLAVES(2)) u_sva (.*, .arvalid(axi.arvalid),
        .arready(axi.arready), .araddr(axi.araddr), .rvalid(axi.rvalid),
        .rready(axi.rready), .rdata(axi.rdata), .rresp(axi.rresp));
    always #2 i_clk = ~i_clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // apb slave: notes each completion, then draws new answers
    always @(posedge i_clk) begin
        if (o_penable && |(o_psel & i_pready)) begin
            e_r = |(o_psel & i_pslverr) ? 2'h2 : 2'h0;
            e_d = i_prdata;
            e_a = o_pwrite ? i_wr_addr : i_rd_addr;
            chk("paddr", e_a, o_paddr);
            chk("psel", 1 << e_a[12], o_psel);
            chk("pprot", o_pwrite ? i_wr_prot : i_rd_prot, o_pprot);
            if (o_pwrite) begin
                chk("pwdata", i_wr_data, o_pwdata);
                chk("pstrb", i_wr_strb, o_pstrb);
            end
        end
        #1;
        s1 = xs(s1);
        {i_pslverr, i_pready, i_prdata} = {s1[3:2], s1[1:0] | s1[5:4], s1};
    end
    // one read, one write or both; answers and their order
    task automatic xfer(input logic dr, dw);
        int n;
        logic rf, wf;
        @(posedge i_clk) #1;
        {rf, wf} = {!dr, !dw};
        {i_rd_req, i_wr_req} = {dr, dw};
        for (n = 0; n < 200 && !(rf && wf); n++) begin
            @(posedge i_clk) #1;
            if (o_rd_busy) i_rd_req = 0;
            if (o_wr_busy) i_wr_req = 0;
            if (o_rd_done && !rf) begin
                rf = 1;
                chk("rdata", i_rd_addr[31:13] ? 0 : e_d, o_rd_data);
                chk("rresp", i_rd_addr[31:13] ? 2 : e_r, o_rd_resp);
            end
            if (o_wr_done && !wf) begin
                wf = 1;
                chk("order", 1, rf);
                chk("bresp", i_wr_addr[31:13] ? 2 : e_r, o_wr_resp);
            end
        end
        mismatches += !(rf && wf);
        if (!(rf && wf)) print_verdict();
    endtask
    initial begin
        int i;
        repeat (5) @(posedge i_clk);
        #1;
        chk("reset", 0, {o_psel, o_penable, axi.rvalid, o_presetn});
        i_arst_n = 1;
        chk("pclk", i_clk, o_pclk);
        for (i = 0; i < 60; i++) begin
            s0 = xs(s0);
            i_rd_addr = i == 0 ? 32'h0000_2000 : {19'h0, s0[12:0]};
            i_wr_addr = i == 1 ? 32'hFFFF_F000 : {19'h0, s0[25:13]};
            i_wr_data = xs(s0);
            {i_wr_strb, i_rd_prot, i_wr_prot} = {s0[27:24], s0[5:0]};
            xfer(i < 3 || s0[30], i < 3 || s0[31] || !s0[30]);
            $display("test %0d done", i);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
